// File: logic/t8w_pkg.sv
package t8w_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTL_A = 8'h00;
  localparam logic [7:0] OFS_CTL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_PIN_DIR = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT_MODE_A_LSB = 6;
  localparam int OUT_MODE_B_LSB = 4;
  localparam int WAVE_LOW_LSB = 0;
  localparam int WAVE_BIT2_POS = 3;
  localparam int CLK_SEL_LSB = 0;
  localparam int ST_OVF = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  localparam logic [7:0] CTL_A_WMASK = 8'hF3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [1:0] RST_DIR = 2'h0;

  // ----------------------------------------------------------------
  // Counter limits and modes
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_A = 3'h5;
  localparam logic [2:0] MODE_FAST_A = 3'h7;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  localparam logic [9:0] PRE_RST = 10'h000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// File: logic/t8w_prescaler.sv
`timescale 1ns/1ns
module t8w_prescaler
  import t8w_pkg::*;
(
  input wire logic clock_i, // System clock
  input wire logic nrst_i, // Async reset, low
  input wire logic [2:0] clk_sel_i, // Prescale select
  output logic tick_o // One-cycle timer enable
);

  logic [9:0] pre_cnt_reg;
  logic tick_reg;
  logic [9:0] mask;

  always_comb
  begin
    mask = PRE_MASK_1024;
    if (clk_sel_i == CS_DIV8)
      mask = PRE_MASK_8;
    else if (clk_sel_i == CS_DIV64)
      mask = PRE_MASK_64;
    else if (clk_sel_i == CS_DIV256)
      mask = PRE_MASK_256;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pre_cnt_reg <= PRE_RST;
    else
      pre_cnt_reg <= pre_cnt_reg + 10'h001;
  end

  // Enable pulse, never a derived clock
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tick_reg <= 1'b0;
    else if (clk_sel_i == CS_DIV1)
      tick_reg <= 1'b1;
    else if (clk_sel_i > CS_DIV1 && clk_sel_i <= CS_DIV1024)
      tick_reg <= (pre_cnt_reg & mask) == mask;
    else
      tick_reg <= 1'b0;
  end

  assign tick_o = tick_reg;

  div8_gap_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (tick_reg && clk_sel_i == CS_DIV8 && $past(clk_sel_i) == CS_DIV8)
    |=> !tick_reg [*7])
  else $error("tick spacing wrong for divide by 8");

endmodule

// File: logic/t8w_timer.sv
// Overview of operation
// - Counter advances only on tick enable
// - Tick divides clock by 1/8/64/256/1024
// - Phase-correct extremes give constant output level
// - Phase-correct: missed up match applied at top
// - Nonzero output mode overrides port function
// - Pin driven only when direction is output
// - A non-PWM: off, toggle, clear, set
// - A fast PWM: toggle needs bit2; clear/set
// - A phase-correct: up/down match clear/set
// - B non-PWM: off, toggle, clear, set
// - B fast PWM: toggle reserved; clear/set
// - B phase-correct: toggle reserved; up/down
// - Fast PWM: match at TOP ignored
// - Phase-correct: match at TOP acts at TOP
// - Mode from low bits plus bit2
// - Mode decode and TOP selection
// - Compare update and overflow point per mode
// - Control A bits 3:2 read zero
`timescale 1ns/1ns
module t8w_timer
  import t8w_pkg::*;
(
  input wire logic clock_i, // 20 MHz clock
  input wire logic nrst_i, // Async reset, low
  input wire logic hsel_i, // AHB select
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB bus ready
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB slave ready
  output logic hresp_o, // AHB response
  output logic wave_out_a_o, // Channel A level
  output logic wave_oe_a_o, // Channel A drive enable
  output logic wave_sel_a_o, // Channel A owns pin
  output logic wave_out_b_o, // Channel B level
  output logic wave_oe_b_o, // Channel B drive enable
  output logic wave_sel_b_o, // Channel B owns pin
  output logic irq_o // Level interrupt
);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] ctl_a_reg;
  logic wave_mode_bit2_reg;
  logic [2:0] clk_sel_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic count_up_reg;
  logic match_block_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [1:0] pin_dir_reg;
  logic irq_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic [31:0] rd_data;
  logic [7:0] cmp_buf_w [2];
  logic [7:0] cmp_act_w [2];
  logic [1:0] wave_w;
  logic [1:0] oe_w;
  logic [1:0] sel_w;
  logic [1:0] hit_w;
  logic [2:0] mode;
  logic is_pc;
  logic is_fast;
  logic is_nonpwm;
  logic [7:0] top;
  logic at_top;
  logic tick;
  logic accept;
  logic rd_status;
  logic cnt_wr;
  logic [7:0] wdata;
  logic ovf_evt;

  assign mode = {wave_mode_bit2_reg, ctl_a_reg[1:0]};
  assign is_pc = mode == MODE_PC_FF || mode == MODE_PC_A;
  assign is_fast = mode == MODE_FAST_FF || mode == MODE_FAST_A;
  assign is_nonpwm = mode == MODE_NORMAL || mode == MODE_CTC;
  assign top = (mode == MODE_CTC || mode == MODE_PC_A ||
                mode == MODE_FAST_A) ? cmp_act_w[0] : CNT_MAX;
  assign at_top = count_reg == top;
  assign accept = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  assign rd_status = accept && !hwrite_i && haddr_i[7:0] == OFS_STATUS;
  assign wdata = hwdata_i[7:0];
  assign cnt_wr = wr_pend_reg && wr_addr_reg == OFS_COUNT;

  t8w_prescaler u_pre (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .clk_sel_i(clk_sel_reg),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes take one wait state, reads none
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (haddr_i[7:0] == OFS_CTL_A)
      rd_data[7:0] = ctl_a_reg & CTL_A_WMASK;
    else if (haddr_i[7:0] == OFS_CTL_B)
      rd_data[7:0] = {4'h0, wave_mode_bit2_reg, clk_sel_reg};
    else if (haddr_i[7:0] == OFS_COUNT)
      rd_data[7:0] = count_reg;
    else if (haddr_i[7:0] == OFS_CMP_A)
      rd_data[7:0] = cmp_buf_w[0];
    else if (haddr_i[7:0] == OFS_CMP_B)
      rd_data[7:0] = cmp_buf_w[1];
    else if (haddr_i[7:0] == OFS_STATUS)
      rd_data[2:0] = status_reg;
    else if (haddr_i[7:0] == OFS_MASK)
      rd_data[2:0] = mask_reg;
    else if (haddr_i[7:0] == OFS_PIN_DIR)
      rd_data[1:0] = pin_dir_reg;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= RST_BYTE;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end
    else if (wr_pend_reg)
    begin
      wr_pend_reg <= 1'b0;
      hready_reg <= 1'b1;
    end
    else if (accept && hwrite_i)
    begin
      wr_pend_reg <= 1'b1;
      wr_addr_reg <= haddr_i[7:0];
      hready_reg <= 1'b0;
    end
    else if (accept)
      hrdata_reg <= rd_data;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctl_a_reg <= RST_BYTE;
      wave_mode_bit2_reg <= 1'b0;
      clk_sel_reg <= RST_CLK_SEL;
      mask_reg <= RST_FLAGS;
      pin_dir_reg <= RST_DIR;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == OFS_CTL_A)
        ctl_a_reg <= wdata & CTL_A_WMASK;
      else if (wr_addr_reg == OFS_CTL_B)
      begin
        wave_mode_bit2_reg <= wdata[WAVE_BIT2_POS];
        clk_sel_reg <= wdata[CLK_SEL_LSB +: 3];
      end
      else if (wr_addr_reg == OFS_MASK)
        mask_reg <= wdata[2:0];
      else if (wr_addr_reg == OFS_PIN_DIR)
        pin_dir_reg <= wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb
  begin
    count_next = count_reg;
    if (is_pc)
    begin
      if (count_up_reg && at_top)
        count_next = count_reg - 8'h01;
      else if (!count_up_reg && count_reg == CNT_BOTTOM)
        count_next = count_reg + 8'h01;
      else if (count_up_reg)
        count_next = count_reg + 8'h01;
      else
        count_next = count_reg - 8'h01;
    end
    else if (mode == MODE_CTC || is_fast)
      count_next = at_top ? CNT_BOTTOM : count_reg + 8'h01;
    else if (mode == MODE_NORMAL)
      count_next = count_reg + 8'h01;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_reg <= RST_BYTE;
      count_up_reg <= 1'b1;
      match_block_reg <= 1'b0;
    end
    else if (cnt_wr)
    begin
      count_reg <= wdata;
      match_block_reg <= 1'b1;
    end
    else if (tick)
    begin
      count_reg <= count_next;
      match_block_reg <= 1'b0;
      if (!is_pc || count_reg == CNT_BOTTOM)
        count_up_reg <= 1'b1;
      else if (at_top)
        count_up_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, read clears, set wins
  // ----------------------------------------------------------------
  always_comb
  begin
    ovf_evt = 1'b0;
    if (tick && !cnt_wr)
    begin
      if (is_pc)
        ovf_evt = !count_up_reg && count_reg == CNT_BOTTOM;
      else if (mode == MODE_FAST_A)
        ovf_evt = at_top;
      else if (is_nonpwm || mode == MODE_FAST_FF)
        ovf_evt = count_reg == CNT_MAX;
    end
    status_next = rd_status ? RST_FLAGS : status_reg;
    status_next[ST_OVF] = status_next[ST_OVF] | ovf_evt;
    status_next[ST_MATCH_A] = status_next[ST_MATCH_A] | hit_w[0];
    status_next[ST_MATCH_B] = status_next[ST_MATCH_B] | hit_w[1];
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_reg <= RST_FLAGS;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Compare channels: A is index 0, B is index 1
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic [7:0] buf_reg;
    logic [7:0] act_reg;
    logic wave_reg;
    logic wave_next;
    logic oe_reg;
    logic sel_reg;
    logic seen_reg;
    logic seen_next;
    logic [1:0] com;
    logic hit;
    logic ign;
    logic tog_ok;
    logic up_ph;
    logic [7:0] ofs;

    assign ofs = (ch == 0) ? OFS_CMP_A : OFS_CMP_B;
    assign com = ctl_a_reg[((ch == 0) ? OUT_MODE_A_LSB : OUT_MODE_B_LSB) +: 2];
    assign hit = tick && !match_block_reg && !cnt_wr &&
                 count_reg == act_reg;
    assign ign = act_reg == top && com[1];
    assign tog_ok = (ch == 0) && wave_mode_bit2_reg;
    assign up_ph = count_up_reg || count_reg == CNT_BOTTOM;

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        buf_reg <= RST_BYTE;
        act_reg <= RST_BYTE;
      end
      else if (wr_pend_reg && wr_addr_reg == ofs)
      begin
        buf_reg <= wdata;
        if (!is_pc && !is_fast)
          act_reg <= wdata;
      end
      else if (tick && at_top && (is_fast || (is_pc && count_up_reg)))
        act_reg <= buf_reg;
    end

    always_comb
    begin
      wave_next = wave_reg;
      seen_next = seen_reg;
      if (is_nonpwm)
      begin
        if (hit && com == 2'h1)
          wave_next = !wave_reg;
        else if (hit && com[1])
          wave_next = com[0];
      end
      else if (is_fast)
      begin
        if (hit && com == 2'h1 && tog_ok)
          wave_next = !wave_reg;
        else if (tick && com[1] && at_top)
          wave_next = !com[0];
        else if (hit && com[1] && !ign)
          wave_next = com[0];
      end
      else if (is_pc)
      begin
        if (hit && com == 2'h1 && tog_ok)
          wave_next = !wave_reg;
        else if (tick && com[1] && count_up_reg && at_top)
        begin
          if (ign)
            wave_next = !com[0];
          else if (!seen_reg && !hit)
            wave_next = com[0];
          seen_next = 1'b0;
        end
        else if (hit && com[1])
        begin
          wave_next = up_ph ? com[0] : !com[0];
          seen_next = seen_reg | up_ph;
        end
      end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        wave_reg <= 1'b0;
        seen_reg <= 1'b0;
        oe_reg <= 1'b0;
        sel_reg <= 1'b0;
      end
      else
      begin
        wave_reg <= wave_next;
        seen_reg <= seen_next;
        sel_reg <= |com;
        oe_reg <= (|com) && pin_dir_reg[ch];
      end
    end

    assign cmp_buf_w[ch] = buf_reg;
    assign cmp_act_w[ch] = act_reg;
    assign wave_w[ch] = wave_reg;
    assign oe_w[ch] = oe_reg;
    assign sel_w[ch] = sel_reg;
    assign hit_w[ch] = hit;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;
  assign wave_out_a_o = wave_w[0];
  assign wave_oe_a_o = oe_w[0];
  assign wave_sel_a_o = sel_w[0];
  assign wave_out_b_o = wave_w[1];
  assign wave_oe_b_o = oe_w[1];
  assign wave_sel_b_o = sel_w[1];
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  count_hold_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (!tick && !cnt_wr) |=> count_reg == $past(count_reg))
  else $error("counter moved without tick");

  pc_zero_low_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_pc && ctl_a_reg[7:6] == 2'h2 && cmp_act_w[0] == 8'h00 && tick &&
     !match_block_reg && count_reg == 8'h00) |=> !wave_w[0])
  else $error("phase correct zero compare not low");

  pin_select_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctl_a_reg[7:6] != 2'h0) |=> wave_sel_a_o)
  else $error("nonzero mode did not take pin");

  drive_dir_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    !pin_dir_reg[1] |=> !wave_oe_b_o)
  else $error("driver on while direction is input");

  toggle_a_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_nonpwm && ctl_a_reg[7:6] == 2'h1 && hit_w[0])
    |=> wave_w[0] != $past(wave_w[0]))
  else $error("channel A did not toggle on match");

  fast_bottom_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_fast && ctl_a_reg[7:6] == 2'h2 && tick && at_top) |=> wave_w[0])
  else $error("fast mode not set at bottom");

  pc_up_clear_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_pc && ctl_a_reg[7:6] == 2'h2 && hit_w[0] && count_up_reg &&
     !at_top) |=> !wave_w[0])
  else $error("up count match did not clear A");

  b_reserved_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_fast && ctl_a_reg[5:4] == 2'h1) |=> $stable(wave_w[1]))
  else $error("reserved B mode changed output");

  ctc_wrap_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (mode == MODE_CTC && tick && !cnt_wr && count_reg == cmp_act_w[0])
    |=> count_reg == 8'h00)
  else $error("clear on match mode did not wrap");

  pc_ovf_a:
  assert property (@(posedge clock_i) disable iff (!nrst_i)
    (is_pc && tick && !cnt_wr && !count_up_reg && count_reg == 8'h00)
    |=> status_reg[0])
  else $error("overflow not flagged at bottom");

endmodule

// File: testbench/t8w_testbench.sv
`timescale 1ns/1ns
module testbench
  import t8w_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic wave_out_a_o, wave_oe_a_o, wave_sel_a_o;
  logic wave_out_b_o, wave_oe_b_o, wave_sel_b_o;
  logic irq_o;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int hi, lo;
  logic [31:0] rd;

  initial
  begin
    forever #25 clock_i = ~clock_i;
  end

  t8w_timer t8w_timer_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .wave_out_a_o(wave_out_a_o), .wave_oe_a_o(wave_oe_a_o),
    .wave_sel_a_o(wave_sel_a_o), .wave_out_b_o(wave_out_b_o),
    .wave_oe_b_o(wave_oe_b_o), .wave_sel_b_o(wave_sel_b_o), .irq_o(irq_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Single AHB transfer; hready is sampled at each rising edge
  task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask

  task automatic cfg(input logic [7:0] ca, cb, cta, ctb);
    wr(OFS_CTL_B, 8'h00);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CMP_A, ca);
    wr(OFS_CMP_B, cb);
    wr(OFS_PIN_DIR, 8'h03);
    wr(OFS_CTL_A, cta);
    wr(OFS_CTL_B, ctb);
  endtask

  function automatic logic wv(input bit ch);
    return ch ? wave_out_b_o : wave_out_a_o;
  endfunction

  // Skips two periods, then counts one high and one low phase
  task automatic measure(input bit ch);
    hi = 0;
    lo = 0;
    repeat (2)
    begin
      while (wv(ch) !== 1'b0) @(posedge clock_i);
      while (wv(ch) !== 1'b1) @(posedge clock_i);
    end
    while (wv(ch) === 1'b1)
    begin
      hi++;
      @(posedge clock_i);
    end
    while (wv(ch) === 1'b0)
    begin
      lo++;
      @(posedge clock_i);
    end
  endtask

  task automatic steady(input bit ch, input logic v);
    int bad;
    bad = 0;
    repeat (1100) @(posedge clock_i);
    repeat (600)
    begin
      @(posedge clock_i);
      if (wv(ch) !== v)
        bad++;
    end
    check(32'(bad), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_regs();
    ahb_xfer(1'b0, OFS_CTL_A, 8'h00, rd);
    check(rd, 32'h0);
    wr(OFS_CTL_A, 8'hFF);
    ahb_xfer(1'b0, OFS_CTL_A, 8'h00, rd);
    check(rd, 32'hF3);
    ahb_xfer(1'b0, 8'h40, 8'h00, rd);
    check(rd, 32'h0);
    check({31'h0, hresp_o}, 32'h0);
    wr(OFS_CTL_A, 8'h00);
  endtask

  task automatic s_normal();
    cfg(8'h20, 8'h00, 8'h40, {5'h0, CS_DIV1});
    measure(1'b0);
    check(32'(hi), 32'd256);
    check(32'(lo), 32'd256);
    check({wave_sel_a_o, wave_oe_a_o, wave_sel_b_o}, 32'h6);
    wr(OFS_PIN_DIR, 8'h02);
    repeat (2) @(posedge clock_i);
    check({wave_sel_a_o, wave_oe_a_o}, 32'h2);
    cfg(8'h20, 8'h00, 8'h40, {5'h0, CS_DIV8});
    measure(1'b0);
    check(32'(hi), 32'd2048);
  endtask

  task automatic s_ctc();
    cfg(8'h09, 8'h03, 8'h52, {5'h0, CS_DIV1});
    measure(1'b0);
    check(32'(hi), 32'd10);
    measure(1'b1);
    check(32'(lo), 32'd10);
    check({wave_sel_b_o, wave_oe_b_o}, 32'h3);
    wr(OFS_PIN_DIR, 8'h01);
    repeat (2) @(posedge clock_i);
    check({wave_sel_b_o, wave_oe_b_o}, 32'h2);
  endtask

  task automatic s_fast();
    logic b_hold;
    cfg(8'h40, 8'h40, 8'hB3, {5'h0, CS_DIV1});
    measure(1'b0);
    check(32'(hi), 32'd65);
    check(32'(lo), 32'd191);
    measure(1'b1);
    check(32'(hi), 32'd191);
    check(32'(lo), 32'd65);
    wr(OFS_CMP_A, 8'hFF);
    steady(1'b0, 1'b1);
    cfg(8'h09, 8'h00, 8'h53, {4'h0, 1'b1, CS_DIV1});
    b_hold = wave_out_b_o;
    measure(1'b0);
    check(32'(hi), 32'd10);
    check({31'h0, wave_out_b_o}, {31'h0, b_hold});
  endtask

  task automatic s_pc();
    cfg(8'h80, 8'h80, 8'hB1, {5'h0, CS_DIV1});
    measure(1'b0);
    check(32'(hi), 32'd256);
    check(32'(lo), 32'd254);
    measure(1'b1);
    check(32'(lo), 32'd256);
    wr(OFS_CMP_A, 8'h00);
    steady(1'b0, 1'b0);
    wr(OFS_CMP_A, 8'hFF);
    steady(1'b0, 1'b1);
    wr(OFS_CTL_A, 8'hF1);
    steady(1'b0, 1'b0);
  endtask

  task automatic s_irq();
    int n;
    cfg(8'h20, 8'h00, 8'h00, {5'h0, CS_DIV1});
    wr(OFS_MASK, 8'h01);
    // Clear flags left over from earlier scenarios
    ahb_xfer(1'b0, OFS_STATUS, 8'h00, rd);
    repeat (2) @(posedge clock_i);
    check({31'h0, irq_o}, 32'h0);
    n = 0;
    while (irq_o !== 1'b1 && n < 600)
    begin
      n++;
      @(posedge clock_i);
    end
    check({31'h0, irq_o}, 32'h1);
    ahb_xfer(1'b0, OFS_STATUS, 8'h00, rd);
    check(rd, 32'h7);
    repeat (3) @(posedge clock_i);
    check({31'h0, irq_o}, 32'h0);
    wr(OFS_MASK, 8'h00);
    repeat (600) @(posedge clock_i);
    check({31'h0, irq_o}, 32'h0);
  endtask

  // Ticks seen over four prescaler periods, read to read
  task automatic span(input logic [7:0] ctb, input int per,
                      input logic [7:0] exp);
    logic [31:0] c0;
    wr(OFS_CTL_B, ctb);
    ahb_xfer(1'b0, OFS_COUNT, 8'h00, c0);
    repeat (4 * per - 2) @(posedge clock_i);
    ahb_xfer(1'b0, OFS_COUNT, 8'h00, rd);
    check({24'h0, rd[7:0] - c0[7:0]}, {24'h0, exp});
  endtask

  task automatic s_div();
    span({5'h0, CS_DIV1}, 1, 8'h04);
    span({5'h0, CS_DIV64}, 64, 8'h04);
    span({5'h0, CS_DIV256}, 256, 8'h04);
    span({5'h0, CS_DIV1024}, 1024, 8'h04);
    span({4'h0, 1'b1, CS_DIV1}, 1, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    s_regs();
    s_normal();
    s_ctc();
    s_fast();
    s_pc();
    s_irq();
    s_div();
    wrap_up();
  end
endmodule
